// >>> hw/uart_fcs_pkg.sv
// Constants shared by the serial frame, control and status logic
package uart_fcs_pkg;
	localparam logic [7:0] ADDR_FRAME_MODE    = 8'h9A;
	localparam logic [7:0] ADDR_CONTROL_FLAGS = 8'h98;
	localparam logic [7:0] RST_FRAME_MODE     = 8'h0C;
	localparam logic [7:0] RST_CONTROL_FLAGS  = 8'h10;
	// Control flag bit positions
	localparam int CF_OVR  = 7;
	localparam int CF_PERR = 6;
	localparam int CF_ONE  = 5;
	localparam int CF_REN  = 4;
	localparam int CF_TBX  = 3;
	localparam int CF_RBX  = 2;
	localparam int CF_TI   = 1;
	localparam int CF_RI   = 0;
	// Frame mode bit positions
	localparam int FM_MCE  = 7;
	localparam int FM_PT_H = 6;
	localparam int FM_PT_L = 5;
	localparam int FM_PE   = 4;
	localparam int FM_DL_H = 3;
	localparam int FM_DL_L = 2;
	localparam int FM_XBE  = 1;
	localparam int FM_SBL  = 0;
	// Parity type codes; five-bit data length code
	localparam logic [1:0] PAR_ODD   = 2'h0;
	localparam logic [1:0] PAR_EVEN  = 2'h1;
	localparam logic [1:0] PAR_MARK  = 2'h2;
	localparam logic [1:0] PAR_SPACE = 2'h3;
	localparam logic [1:0] DL_FIVE   = 2'h0;
	// Oversampling (16 ticks per bit): last tick index, mid-start sample index; receive FIFO depth; word width
	localparam logic [3:0] SUB_LAST  = 4'hF;
	localparam logic [3:0] SUB_MID   = 4'h7;
	localparam logic [1:0] RX_DEPTH  = 2'h3;
	localparam int         WORD_W    = 8;

	typedef enum logic [4:0] {
		TX_IDLE  = 5'h01,
		TX_START = 5'h02,
		TX_DATA  = 5'h04,
		TX_EXTRA = 5'h08,
		TX_STOP  = 5'h10
	} tx_state_e;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_EXTRA = 5'h08,
		RX_STOP  = 5'h10
	} rx_state_e;
endpackage

// >>> hw/stream_buf2.sv
// Two-entry valid/ready buffer
module stream_buf2 #(
	parameter int W = 8
) (
	input  wire logic         i_clk,
	input  wire logic         i_srst,
	input  wire logic         i_ce,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic [W-1:0]      o_out_data
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic [1:0]        cnt;
		logic              rdy;
	} buf_s;

	buf_s st_r;
	buf_s st_nxt;
	logic push;
	logic pop;

	// Ready from a flop, so no combinational path reaches the source
	assign o_in_ready  = st_r.rdy;
	assign o_out_valid = (st_r.cnt != 2'h0);
	assign o_out_data  = st_r.mem[0];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb begin
		st_nxt = st_r;
		if (pop) begin
			st_nxt.mem[0] = st_r.mem[1];
			st_nxt.cnt    = st_r.cnt - 2'h1;
		end
		if (push) begin
			st_nxt.mem[st_nxt.cnt[0]] = i_in_data;
			st_nxt.cnt                = st_nxt.cnt + 2'h1;
		end
		st_nxt.rdy = (st_nxt.cnt != 2'h2);
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_r     <= '0;
			st_r.rdy <= 1'b1;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end
endmodule // stream_buf2

// >>> hw/uart_frame_control_status.sv
// Serial port frame format, control flags, status flags and bit engines
////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE1: With parity on, a wrong received parity bit sets the sticky parity error flag.
// RULE2: Receive enable low blocks new frames; held FIFO bytes remain readable.
// RULE3: Length field picks five to eight data bits for both directions.
// RULE4: Frame sent sets transmit done; it requests interrupt; only software clears.
// RULE5: Three-byte receive FIFO; byte arriving when full is dropped, overrun set.
// RULE6: Multiprocessor mode raises receive done only when stop and extra bits are one.
// RULE7: Two stop bits apply only to six, seven or eight data bits.
// RULE8: Parity on disables extra bit and filtering; parity takes that position.
// RULE9: Odd, even, mark and space parity carry their usual meanings.
module uart_frame_control_status (
	input  wire logic       I_CLK_SYS,
	input  wire logic       I_SRST,
	input  wire logic       I_CE,
	input  wire logic       I_BAUD_TICK16,
	input  wire logic [7:0] I_SFR_ADDR,
	input  wire logic       I_SFR_WR,
	input  wire logic       I_SFR_RD,
	input  wire logic [7:0] I_SFR_WDATA,
	output logic [7:0]      O_SFR_RDATA,
	input  wire logic       I_TX_VALID,
	output logic            O_TX_READY,
	input  wire logic [7:0] I_TX_DATA,
	output logic            O_RX_VALID,
	output logic [7:0]      O_RX_DATA,
	input  wire logic       I_RX_POP,
	input  wire logic       I_INT_EN,
	output logic            O_IRQ,
	input  wire logic       I_RXD,
	output logic            O_TXD
);
	typedef struct packed {
		logic [7:0]                       mode;
		logic [7:0]                       ctrl;
		logic [7:0]                       rdata;
		uart_fcs_pkg::tx_state_e          tx_state;
		logic [3:0]                       tx_sub;
		logic [2:0]                       tx_idx;
		logic [7:0]                       tx_sh;
		logic                             tx_par;
		logic                             txd;
		uart_fcs_pkg::rx_state_e          rx_state;
		logic [3:0]                       rx_sub;
		logic [2:0]                       rx_idx;
		logic [7:0]                       rx_sh;
		logic                             rx_xbit;
		logic                             rx_stop_ok;
		logic                             rx_s1;
		logic                             rx_s2;
		logic [2:0][8:0]                  fifo;
		logic [1:0]                       cnt;
		logic                             rx_valid;
		logic                             irq;
	} core_s;

	core_s core_r;
	core_s core_nxt;
	logic       buf_valid;
	logic [7:0] buf_data;
	logic       buf_take;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [2:0] last_idx(input logic [1:0] dl);
		last_idx = {1'b0, dl} + 3'h4; // RULE3
	endfunction

	function automatic logic [7:0] mask_data(input logic [7:0] d, input logic [1:0] dl);
		mask_data = d & (8'hFF >> (2'h3 - dl)); // RULE3
	endfunction

	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] pt);
		case (pt) // RULE9
			uart_fcs_pkg::PAR_ODD:  par_bit = ~^d;
			uart_fcs_pkg::PAR_EVEN: par_bit = ^d;
			uart_fcs_pkg::PAR_MARK: par_bit = 1'b1;
			default:                par_bit = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Transmit word buffer; a stalled engine back-pressures the source

	stream_buf2 #(
		.W (uart_fcs_pkg::WORD_W)
	) u_tx_buf (
		.i_clk       (I_CLK_SYS),
		.i_srst      (I_SRST),
		.i_ce        (I_CE),
		.i_in_valid  (I_TX_VALID),
		.o_in_ready  (O_TX_READY),
		.i_in_data   (I_TX_DATA),
		.o_out_valid (buf_valid),
		.i_out_ready (buf_take),
		.o_out_data  (buf_data)
	);

	assign buf_take = (core_r.tx_state == uart_fcs_pkg::TX_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [1:0] dl;
		logic [1:0] pt;
		logic       pe;
		logic       xbe_eff;
		logic       mce_eff;
		logic       two_stop;
		logic       ti_set;
		logic       ri_set;
		logic       ovr_set;
		logic       perr_set;
		logic       push;
		logic       pop;
		logic       rbx;
		logic [7:0] rx_word;
		logic       wr_ctrl;
		dl       = core_r.mode[uart_fcs_pkg::FM_DL_H:uart_fcs_pkg::FM_DL_L];
		pt       = core_r.mode[uart_fcs_pkg::FM_PT_H:uart_fcs_pkg::FM_PT_L];
		pe       = core_r.mode[uart_fcs_pkg::FM_PE];
		xbe_eff  = core_r.mode[uart_fcs_pkg::FM_XBE] & ~pe; // RULE8
		mce_eff  = core_r.mode[uart_fcs_pkg::FM_MCE] & ~pe; // RULE8
		two_stop = core_r.mode[uart_fcs_pkg::FM_SBL] && (dl != uart_fcs_pkg::DL_FIVE); // RULE7
		ti_set   = 1'b0;
		ri_set   = 1'b0;
		ovr_set  = 1'b0;
		perr_set = 1'b0;
		push     = 1'b0;
		pop      = I_RX_POP && (core_r.cnt != 2'h0); // RULE2
		rbx      = 1'b0;
		rx_word  = 8'h00;
		wr_ctrl  = I_SFR_WR && (I_SFR_ADDR == uart_fcs_pkg::ADDR_CONTROL_FLAGS);
		core_nxt = core_r;

		// Pin synchroniser
		core_nxt.rx_s1 = I_RXD;
		core_nxt.rx_s2 = core_r.rx_s1;

		// Transmit engine
		case (core_r.tx_state)
			uart_fcs_pkg::TX_IDLE: begin
				core_nxt.txd = 1'b1;
				if (buf_valid) begin
					core_nxt.tx_sh    = mask_data(buf_data, dl);
					core_nxt.tx_par   = par_bit(mask_data(buf_data, dl), pt); // RULE9
					core_nxt.tx_state = uart_fcs_pkg::TX_START;
					core_nxt.tx_sub   = 4'h0;
					core_nxt.txd      = 1'b0;
				end
			end
			uart_fcs_pkg::TX_START: begin
				if (I_BAUD_TICK16) begin
					core_nxt.tx_sub = core_r.tx_sub + 4'h1;
					if (core_r.tx_sub == uart_fcs_pkg::SUB_LAST) begin
						core_nxt.tx_state = uart_fcs_pkg::TX_DATA;
						core_nxt.tx_idx   = 3'h0;
						core_nxt.txd      = core_r.tx_sh[0];
					end
				end
			end
			uart_fcs_pkg::TX_DATA: begin
				if (I_BAUD_TICK16) begin
					core_nxt.tx_sub = core_r.tx_sub + 4'h1;
					if (core_r.tx_sub == uart_fcs_pkg::SUB_LAST) begin
						core_nxt.tx_sh  = {1'b0, core_r.tx_sh[7:1]};
						core_nxt.tx_idx = core_r.tx_idx + 3'h1;
						core_nxt.txd    = core_r.tx_sh[1];
						if (core_r.tx_idx == last_idx(dl)) begin // RULE3
							if (pe || xbe_eff) begin
								core_nxt.tx_state = uart_fcs_pkg::TX_EXTRA;
								// Parity takes the extra bit slot
								core_nxt.txd = pe ? core_r.tx_par
									: core_r.ctrl[uart_fcs_pkg::CF_TBX]; // RULE8
							end else begin
								core_nxt.tx_state = uart_fcs_pkg::TX_STOP;
								core_nxt.tx_idx   = 3'h0;
								core_nxt.txd      = 1'b1;
								ti_set            = 1'b1; // RULE4
							end
						end
					end
				end
			end
			uart_fcs_pkg::TX_EXTRA: begin
				if (I_BAUD_TICK16) begin
					core_nxt.tx_sub = core_r.tx_sub + 4'h1;
					if (core_r.tx_sub == uart_fcs_pkg::SUB_LAST) begin
						core_nxt.tx_state = uart_fcs_pkg::TX_STOP;
						core_nxt.tx_idx   = 3'h0;
						core_nxt.txd      = 1'b1;
						ti_set            = 1'b1; // RULE4
					end
				end
			end
			uart_fcs_pkg::TX_STOP: begin
				core_nxt.txd = 1'b1;
				if (I_BAUD_TICK16) begin
					core_nxt.tx_sub = core_r.tx_sub + 4'h1;
					if (core_r.tx_sub == uart_fcs_pkg::SUB_LAST) begin
						if (two_stop && (core_r.tx_idx == 3'h0)) begin // RULE7
							core_nxt.tx_idx = 3'h1;
						end else begin
							core_nxt.tx_state = uart_fcs_pkg::TX_IDLE;
						end
					end
				end
			end
			default: begin
				core_nxt.tx_state = uart_fcs_pkg::TX_IDLE;
			end
		endcase

		// Receive engine; samples mid-bit, 16 ticks apart after the start check
		case (core_r.rx_state)
			uart_fcs_pkg::RX_IDLE: begin
				if (core_r.ctrl[uart_fcs_pkg::CF_REN] && !core_r.rx_s2) begin // RULE2
					core_nxt.rx_state   = uart_fcs_pkg::RX_START;
					core_nxt.rx_sub     = 4'h0;
					core_nxt.rx_stop_ok = 1'b1;
				end
			end
			uart_fcs_pkg::RX_START: begin
				if (I_BAUD_TICK16) begin
					core_nxt.rx_sub = core_r.rx_sub + 4'h1;
					if (core_r.rx_sub == uart_fcs_pkg::SUB_MID) begin
						// A glitch shorter than half a bit is not a start
						core_nxt.rx_state = core_r.rx_s2 ? uart_fcs_pkg::RX_IDLE
							: uart_fcs_pkg::RX_DATA;
						core_nxt.rx_sub = 4'h0;
						core_nxt.rx_idx = 3'h0;
					end
				end
			end
			uart_fcs_pkg::RX_DATA: begin
				if (I_BAUD_TICK16) begin
					core_nxt.rx_sub = core_r.rx_sub + 4'h1;
					if (core_r.rx_sub == uart_fcs_pkg::SUB_LAST) begin
						core_nxt.rx_sh  = {core_r.rx_s2, core_r.rx_sh[7:1]};
						core_nxt.rx_idx = core_r.rx_idx + 3'h1;
						if (core_r.rx_idx == last_idx(dl)) begin // RULE3
							core_nxt.rx_state = (pe || xbe_eff) ? uart_fcs_pkg::RX_EXTRA
								: uart_fcs_pkg::RX_STOP;
							core_nxt.rx_idx = 3'h0;
						end
					end
				end
			end
			uart_fcs_pkg::RX_EXTRA: begin
				if (I_BAUD_TICK16) begin
					core_nxt.rx_sub = core_r.rx_sub + 4'h1;
					if (core_r.rx_sub == uart_fcs_pkg::SUB_LAST) begin
						core_nxt.rx_xbit  = core_r.rx_s2;
						core_nxt.rx_state = uart_fcs_pkg::RX_STOP;
					end
				end
			end
			uart_fcs_pkg::RX_STOP: begin
				if (I_BAUD_TICK16) begin
					core_nxt.rx_sub = core_r.rx_sub + 4'h1;
					if (core_r.rx_sub == uart_fcs_pkg::SUB_LAST) begin
						core_nxt.rx_stop_ok = core_r.rx_stop_ok & core_r.rx_s2;
						// Parity keeps its slot, so a second stop cannot hide it
						if (core_r.rx_idx == 3'h0 && !(pe || xbe_eff)) begin
							// Without an extra bit the first stop bit is reported
							core_nxt.rx_xbit = core_r.rx_s2;
						end
						if (two_stop && (core_r.rx_idx == 3'h0)) begin // RULE7
							core_nxt.rx_idx = 3'h1;
						end else begin
							core_nxt.rx_state = uart_fcs_pkg::RX_IDLE;
							rx_word = mask_data(core_r.rx_sh >> (2'h3 - dl), dl);
							rbx     = core_nxt.rx_xbit;
							if (pe && (core_r.rx_xbit != par_bit(rx_word, pt))) begin
								perr_set = 1'b1; // RULE1
							end
							if (core_nxt.rx_stop_ok) begin
								if (core_r.cnt == uart_fcs_pkg::RX_DEPTH && !pop) begin
									ovr_set = 1'b1; // RULE5
								end else begin
									push = 1'b1;
									// Filter needs the extra bit; stops already checked
									ri_set = !mce_eff || rbx; // RULE6
								end
							end
						end
					end
				end
			end
			default: begin
				core_nxt.rx_state = uart_fcs_pkg::RX_IDLE;
			end
		endcase

		// Receive FIFO, head at entry 0
		if (pop) begin
			core_nxt.fifo[0] = core_r.fifo[1];
			core_nxt.fifo[1] = core_r.fifo[2];
			core_nxt.cnt     = core_r.cnt - 2'h1;
		end
		if (push) begin
			core_nxt.fifo[core_nxt.cnt] = {rbx, rx_word}; // RULE5
			core_nxt.cnt                = core_nxt.cnt + 2'h1;
		end
		core_nxt.rx_valid = (core_nxt.cnt != 2'h0);

		// Register writes; hardware sets win over a same-cycle clear
		if (I_SFR_WR && (I_SFR_ADDR == uart_fcs_pkg::ADDR_FRAME_MODE)) begin
			core_nxt.mode = I_SFR_WDATA;
		end
		if (wr_ctrl) begin
			core_nxt.ctrl = I_SFR_WDATA;
		end
		core_nxt.ctrl[uart_fcs_pkg::CF_ONE] = 1'b0;
		core_nxt.ctrl[uart_fcs_pkg::CF_RBX] = 1'b0;
		if (ovr_set) begin
			core_nxt.ctrl[uart_fcs_pkg::CF_OVR] = 1'b1; // RULE5
		end
		if (perr_set) begin
			core_nxt.ctrl[uart_fcs_pkg::CF_PERR] = 1'b1; // RULE1
		end
		if (ti_set) begin
			core_nxt.ctrl[uart_fcs_pkg::CF_TI] = 1'b1; // RULE4
		end
		if (ri_set) begin
			core_nxt.ctrl[uart_fcs_pkg::CF_RI] = 1'b1; // RULE6
		end
		core_nxt.irq = I_INT_EN && (core_nxt.ctrl[uart_fcs_pkg::CF_TI]
			|| core_nxt.ctrl[uart_fcs_pkg::CF_RI]); // RULE4

		// Read data, registered one cycle after the strobe
		if (I_SFR_RD) begin
			if (I_SFR_ADDR == uart_fcs_pkg::ADDR_FRAME_MODE) begin
				core_nxt.rdata = core_r.mode;
			end else if (I_SFR_ADDR == uart_fcs_pkg::ADDR_CONTROL_FLAGS) begin
				core_nxt.rdata = core_r.ctrl;
				core_nxt.rdata[uart_fcs_pkg::CF_ONE] = 1'b1;
				// Stale entries stay in the array; empty reads zero
				core_nxt.rdata[uart_fcs_pkg::CF_RBX] = core_r.fifo[0][8] && core_r.rx_valid;
			end else begin
				core_nxt.rdata = 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			core_r          <= '0;
			core_r.mode     <= uart_fcs_pkg::RST_FRAME_MODE;
			core_r.ctrl     <= uart_fcs_pkg::RST_CONTROL_FLAGS;
			core_r.tx_state <= uart_fcs_pkg::TX_IDLE;
			core_r.rx_state <= uart_fcs_pkg::RX_IDLE;
			core_r.txd      <= 1'b1;
			core_r.rx_s1    <= 1'b1;
			core_r.rx_s2    <= 1'b1;
		end else if (I_CE) begin
			core_r <= core_nxt;
		end
	end

	assign O_SFR_RDATA = core_r.rdata;
	assign O_RX_VALID  = core_r.rx_valid;
	assign O_RX_DATA   = core_r.fifo[0][7:0];
	assign O_IRQ       = core_r.irq;
	assign O_TXD       = core_r.txd;
endmodule // uart_frame_control_status

// >>> tb/uart_fcs_chk.sv
// Port-level checks for the serial frame, control and status block
module uart_fcs_chk (
	input wire logic       I_CLK_SYS,
	input wire logic       I_SRST,
	input wire logic       I_CE,
	input wire logic [7:0] I_SFR_ADDR,
	input wire logic       I_SFR_WR,
	input wire logic       I_SFR_RD,
	input wire logic [7:0] I_SFR_WDATA,
	input wire logic [7:0] O_SFR_RDATA,
	input wire logic       O_TX_READY,
	input wire logic       O_RX_VALID,
	input wire logic [7:0] O_RX_DATA,
	input wire logic       I_RX_POP,
	input wire logic       I_INT_EN,
	input wire logic       O_IRQ,
	input wire logic       O_TXD
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SRST);
	////////////////////////////////////////////////////////////////////////////////
	sequence mode_wr_s;
		I_CE && I_SFR_WR && I_SFR_ADDR == uart_fcs_pkg::ADDR_FRAME_MODE;
	endsequence
	sequence mode_rd_s;
		I_CE && I_SFR_RD && !I_SFR_WR && I_SFR_ADDR == uart_fcs_pkg::ADDR_FRAME_MODE;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	chk_reset_outputs: assert property ($fell(I_SRST) |-> O_TXD && O_TX_READY
		&& !O_RX_VALID && !O_IRQ && O_SFR_RDATA == 8'h00) else $error("bad reset outputs");
	chk_mode_readback: assert property (mode_wr_s ##1 mode_rd_s
		|=> O_SFR_RDATA == $past(I_SFR_WDATA, 2)) else $error("mode readback differs");
	chk_irq_gated: assert property (I_CE && !I_INT_EN |=> !O_IRQ)
		else $error("irq while disabled");
	chk_irq_cause: assert property ($rose(O_IRQ) |-> $past(I_INT_EN))
		else $error("irq rose without enable");
	chk_unmapped_zero: assert property (I_CE && I_SFR_RD
		&& I_SFR_ADDR != uart_fcs_pkg::ADDR_FRAME_MODE
		&& I_SFR_ADDR != uart_fcs_pkg::ADDR_CONTROL_FLAGS |=> O_SFR_RDATA == 8'h00)
		else $error("unmapped read not zero");
	chk_unused_one: assert property (I_CE && I_SFR_RD
		&& I_SFR_ADDR == uart_fcs_pkg::ADDR_CONTROL_FLAGS
		|=> O_SFR_RDATA[uart_fcs_pkg::CF_ONE]) else $error("unused bit not one");
	chk_rdata_hold: assert property (!(I_CE && I_SFR_RD) |=> $stable(O_SFR_RDATA))
		else $error("read data moved");
	chk_rx_head_hold: assert property (O_RX_VALID && !(I_CE && I_RX_POP)
		|=> O_RX_VALID && $stable(O_RX_DATA)) else $error("fifo head lost");
endmodule // uart_fcs_chk

// >>> tb/uart_fcs_remote.sv
// Remote serial node: drives frames on the receive line, samples the transmit line
module uart_fcs_remote (
	input  wire logic i_clk,
	input  wire logic i_txd,
	output logic      o_rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	// Line idles at mark level between frames
	initial o_rxd = 1'b1;
	// Bit cells are 16 clocks: the bench ticks the oversampler every clock
	task automatic drive(input logic [31:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			o_rxd = f[i];
			repeat (16) @(negedge i_clk);
		end
		// Last cell is a stop bit, so the line is already back at idle
	endtask
	// Samples mid-cell on falling edges, where the line has settled
	task automatic grab(output logic [15:0] w);
		@(negedge i_clk);
		while (i_txd)
			@(negedge i_clk);
		repeat (8) @(negedge i_clk);
		for (int i = 0; i < 16; i++) begin
			w[i] = i_txd;
			repeat (16) @(negedge i_clk);
		end
	endtask
endmodule // uart_fcs_remote

// >>> tb/uart_frame_control_status_tb_top.sv
// Self-checking bench for the serial frame, control and status block
module uart_frame_control_status_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, srst, sfr_wr, sfr_rd, tx_valid, tx_ready, rx_valid, rx_pop, int_en;
	logic        irq, rxd, txd;
	logic [7:0]  addr, wdata, rdata, tx_data, rx_data, m;
	logic [15:0] w;
	logic [31:0] f;
	logic [7:0]  tx_modes [5] = '{8'h1D, 8'h31, 8'h76, 8'h59, 8'h0E};
	int          n;
	int          miscompares = 0;
	int          total_checks = 0;
	uart_frame_control_status u_dut (.I_CLK_SYS(clk), .I_SRST(srst), .I_CE(1'b1),
		.I_BAUD_TICK16(1'b1), .I_SFR_ADDR(addr), .I_SFR_WR(sfr_wr), .I_SFR_RD(sfr_rd),
		.I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata), .I_TX_VALID(tx_valid),
		.O_TX_READY(tx_ready), .I_TX_DATA(tx_data), .O_RX_VALID(rx_valid),
		.O_RX_DATA(rx_data), .I_RX_POP(rx_pop), .I_INT_EN(int_en), .O_IRQ(irq),
		.I_RXD(rxd), .O_TXD(txd));
	uart_fcs_remote u_rem (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Frame bits LSB first, idle ones beyond the last stop
	function automatic logic [31:0] frm(input logic [7:0] d, mo, input logic xb, output int n);
		int          nb;
		logic        p;
		logic [31:0] fr;
		nb = 5 + int'(mo[3:2]);
		fr = '1;
		fr[0] = 1'b0;
		for (int i = 0; i < nb; i++)
			fr[1+i] = d[i];
		p = ^(d & ((32'h1 << nb) - 1));
		if (mo[6:5] != 2'h1)
			p = (mo[6:5] == 2'h2) || (mo[6:5] == 2'h0 && !p);
		n = 1 + nb;
		if (mo[4] || mo[1]) begin
			fr[n] = mo[4] ? p : xb;
			n++;
		end
		n += (mo[0] && nb > 5) ? 2 : 1;
		return fr;
	endfunction
	task automatic cmp(input logic [15:0] act, input logic [15:0] exp);
		total_checks++;
		if (act !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic bus(input logic w_, r_, input logic [7:0] a, d);
		sfr_wr = w_;
		sfr_rd = r_;
		addr = a;
		wdata = d;
		@(negedge clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, d);
	endtask
	task automatic rd_reg(input logic [7:0] a, exp);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		cmp({8'h00, rdata}, {8'h00, exp});
	endtask
	// Two words with valid held high, so the second is offered back to back
	task automatic push2(input logic [7:0] d);
		tx_data = d;
		tx_valid = 1'b1;
		repeat (2) begin
			@(posedge clk);
			while (!tx_ready)
				@(posedge clk);
			@(negedge clk);
		end
		tx_valid = 1'b0;
	endtask
	task automatic pop();
		rx_pop = 1'b1;
		@(negedge clk);
		rx_pop = 1'b0;
		@(negedge clk);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		stop_test;
	end
	initial begin
		srst = 1'b1;
		{sfr_wr, sfr_rd, tx_valid, rx_pop, int_en} = '0;
		{addr, wdata, tx_data} = '0;
		repeat (4) @(negedge clk);
		srst = 1'b0;
		rd_reg(8'h9A, 8'h0C);
		rd_reg(8'h98, 8'h30);
		rd_reg(8'h55, 8'h00);
		bus(1'b1, 1'b0, 8'h9A, 8'h5B);
		rd_reg(8'h9A, 8'h5B);
		int_en = 1'b1;
		wr_reg(8'h98, 8'h18);
		$display("test registers done");
		foreach (tx_modes[i]) begin
			wr_reg(8'h9A, tx_modes[i]);
			fork
				push2(8'hB4);
				u_rem.grab(w);
			join
			repeat (200) @(negedge clk);
			f = frm(8'hB4, tx_modes[i], 1'b1, n);
			cmp(w, 16'((f & ((32'h1 << n) - 1)) | (f << n)));
			rd_reg(8'h98, 8'h3A);
			cmp(16'(irq), 16'h1);
			int_en = 1'b0;
			repeat (2) @(negedge clk);
			cmp(16'(irq), 16'h0);
			int_en = 1'b1;
			wr_reg(8'h98, 8'h18);
			rd_reg(8'h98, 8'h38);
			cmp(16'(irq), 16'h0);
		end
		$display("test transmit done");
		for (int pt = 0; pt < 4; pt++) begin
			m = 8'h1C | 8'(pt << 5);
			wr_reg(8'h9A, m);
			f = frm(8'hC5, m, 1'b0, n);
			u_rem.drive(f, n);
			cmp({8'h00, rx_data}, 16'h00C5);
			pop();
			rd_reg(8'h98, 8'h39);
			u_rem.drive(f ^ 32'h200, n);
			pop();
			rd_reg(8'h98, 8'h79);
			wr_reg(8'h98, 8'h18);
		end
		$display("test parity done");
		wr_reg(8'h9A, 8'h0C);
		for (int i = 1; i < 5; i++) begin
			f = frm(8'(i * 17), 8'h0C, 1'b0, n);
			u_rem.drive(f, n);
		end
		rd_reg(8'h98, 8'hBD);
		wr_reg(8'h98, 8'h08);
		f = frm(8'h44, 8'h0C, 1'b0, n);
		u_rem.drive(f, n);
		for (int i = 1; i < 4; i++) begin
			cmp({8'h00, rx_data}, 16'(i * 17));
			pop();
		end
		cmp(16'(rx_valid), 16'h0);
		rd_reg(8'h98, 8'h28);
		$display("test fifo done");
		wr_reg(8'h98, 8'h18);
		wr_reg(8'h9A, 8'h82);
		f = frm(8'h1A, 8'h82, 1'b0, n);
		u_rem.drive(f, n);
		rd_reg(8'h98, 8'h38);
		cmp({8'h00, rx_data}, 16'h001A);
		pop();
		f = frm(8'h1A, 8'h82, 1'b1, n);
		u_rem.drive(f, n);
		rd_reg(8'h98, 8'h3D);
		pop();
		$display("test multiprocessor done");
		stop_test;
	end
endmodule // uart_frame_control_status_tb_top

bind uart_frame_control_status uart_fcs_chk u_chk (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST),
	.I_CE(I_CE), .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD),
	.I_SFR_WDATA(I_SFR_WDATA), .O_SFR_RDATA(O_SFR_RDATA), .O_TX_READY(O_TX_READY),
	.O_RX_VALID(O_RX_VALID), .O_RX_DATA(O_RX_DATA), .I_RX_POP(I_RX_POP),
	.I_INT_EN(I_INT_EN), .O_IRQ(O_IRQ), .O_TXD(O_TXD));
